// >>> hdl/mpg_consts.vh
// Register map, field positions, reset values and bus codes of the motor PWM generator core
`ifndef MPG_CONSTS_VH
`define MPG_CONSTS_VH
// Register byte offsets
`define MPG_DT_C       8'h00
`define MPG_DT_A       8'h04
`define MPG_DT_B       8'h08
`define MPG_CFG        8'h0C
`define MPG_CTL        8'h10
`define MPG_MOD_A      8'h14
`define MPG_MOD_B      8'h18
`define MPG_VAL0       8'h1C
`define MPG_VAL5       8'h30
`define MPG_MOD_C      8'h34
`define MPG_CNT_A      8'h38
`define MPG_CNT_B      8'h3C
`define MPG_CNT_C      8'h40
`define MPG_EDT_A      8'h44
`define MPG_EDT_B      8'h48
`define MPG_EDT_C      8'h4C
// Configuration register fields
`define MPG_CFG_MTG    0
`define MPG_CFG_WP     1
`define MPG_CFG_EDGE   2
// Control register fields (three bits or three two-bit groups each)
`define MPG_CTL_EN     0
`define MPG_CTL_LDOK   4
`define MPG_CTL_PSC    8
// Reset values
`define MPG_DT_RST     12'hFFF
`define MPG_MOD_RST    15'h0000
`define MPG_VAL_RST    16'h0000
// AXI response codes
`define MPG_RESP_OKAY  2'b00
`define MPG_RESP_SLVERR 2'b10
`endif

// >>> hdl/mpg_gen.v
// One PWM generator: prescaler, up/down counter, buffered working copies and two outputs
`timescale 1ns/1ps
`include "mpg_consts.vh"
module mpg_gen #(
    parameter CW = 15,                   // Counter and modulus width
    parameter VW = 16                    // Signed pulse width value width
) (
    input  wire          aclk,
    input  wire          aresetn,
    input  wire          enable,
    input  wire          edge_align_select,
    input  wire          load_okay,
    input  wire [1:0]    psc_buf,
    input  wire [CW-1:0] mod_buf,
    input  wire [VW-1:0] val0_buf,
    input  wire [VW-1:0] val1_buf,
    output wire [CW-1:0] count,
    output wire [1:0]    psc_work,
    output wire          loaded,
    output wire          out0,
    output wire          out1
);
    reg  [1:0]    psc_ff;                // Working prescaler select
    reg  [CW-1:0] mod_ff;                // Working modulus
    reg  [VW-1:0] val0_ff;               // Working value, even output
    reg  [VW-1:0] val1_ff;               // Working value, odd output
    reg  [2:0]    div_ff;                // Bus clock divider
    reg  [CW-1:0] cnt_ff;                // PWM counter
    reg           down_ff;               // Counting downward
    reg           first_ff;              // Next tick starts a fresh period
    reg           loaded_ff;             // Buffers taken this cycle
    reg           out0_ff;
    reg           out1_ff;
    reg  [2:0]    div_last;              // Last divider state per divisor
    reg  [CW-1:0] nxt_cnt;
    reg           nxt_down;
    reg           wrap;                  // Next count begins a period
    wire [CW-1:0] mod_m1  = mod_ff - {{(CW-1){1'b0}}, 1'b1};
    wire          tick    = (div_ff == div_last);
    wire          reload  = enable & tick & wrap;
    // Idle generator takes buffers at once so enabling starts on fresh values
    wire          do_load = load_okay & (reload | ~enable);
    wire [CW-1:0] mod_use = do_load ? mod_buf : mod_ff;
    wire [VW-1:0] v0_use  = do_load ? val0_buf : val0_ff;
    wire [VW-1:0] v1_use  = do_load ? val1_buf : val1_ff;

    assign count    = cnt_ff;
    assign psc_work = psc_ff;
    assign loaded   = loaded_ff;
    assign out0     = out0_ff;
    assign out1     = out1_ff;

    // Output state after a tick, from equality compares except the at-or-above-modulus check at reload
    function nxt_out;
        input [VW-1:0] v;
        input [CW-1:0] m;
        input [CW-1:0] n;
        input          dn;
        input          rl;
        input          ed;
        input          cur;
        reg   [CW-1:0] vp;
        reg   [CW:0]   thr;
        begin
            vp  = v[VW-1] ? {CW{1'b0}} : v[CW-1:0];
            thr = {1'b0, m} - {1'b0, vp};
            if (rl) begin
                // Zero or negative stays off; at or above modulus stays on
                nxt_out = (vp != {CW{1'b0}}) && (ed || (vp >= m));
            end else if (ed) begin
                nxt_out = (n == vp) ? 1'b0 : cur;
            end else if ({1'b0, n} == thr) begin
                nxt_out = ~dn;
            end else begin
                nxt_out = cur;
            end
        end
    endfunction

    // Divisor of one, two, four or eight
    always @* begin
        case (psc_ff)
            2'b00:   div_last = 3'h0;
            2'b01:   div_last = 3'h1;
            2'b10:   div_last = 3'h3;
            default: div_last = 3'h7;
        endcase
    end

    // Next counter value and direction
    always @* begin
        nxt_cnt  = cnt_ff;
        nxt_down = down_ff;
        wrap     = 1'b0;
        if (first_ff) begin
            nxt_cnt  = {CW{1'b0}};
            nxt_down = 1'b0;
            wrap     = 1'b1;
        end else if (mod_ff == {CW{1'b0}}) begin
            // Illegal modulus: free run downward through the maximum
            nxt_cnt  = cnt_ff - {{(CW-1){1'b0}}, 1'b1};
            nxt_down = 1'b1;
            wrap     = (cnt_ff == {CW{1'b0}});
        end else if (edge_align_select) begin
            nxt_down = 1'b0;
            if (cnt_ff >= mod_m1) begin
                nxt_cnt = {CW{1'b0}};
                wrap    = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + {{(CW-1){1'b0}}, 1'b1};
            end
        end else if (!down_ff) begin
            if (cnt_ff >= mod_m1) begin
                nxt_cnt  = mod_ff;
                nxt_down = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + {{(CW-1){1'b0}}, 1'b1};
            end
        end else begin
            if (cnt_ff <= {{(CW-1){1'b0}}, 1'b1}) begin
                nxt_cnt  = {CW{1'b0}};
                nxt_down = 1'b0;
                wrap     = 1'b1;
            end else begin
                nxt_cnt = cnt_ff - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    // Counter, reload and outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            psc_ff    <= 2'b00;
            mod_ff    <= `MPG_MOD_RST;
            val0_ff   <= `MPG_VAL_RST;
            val1_ff   <= `MPG_VAL_RST;
            div_ff    <= 3'h0;
            cnt_ff    <= {CW{1'b0}};
            down_ff   <= 1'b0;
            first_ff  <= 1'b1;
            loaded_ff <= 1'b0;
            out0_ff   <= 1'b0;
            out1_ff   <= 1'b0;
        end else begin
            loaded_ff <= do_load;
            // All working copies change together at one boundary
            if (do_load) begin
                psc_ff  <= psc_buf;
                mod_ff  <= mod_buf;
                val0_ff <= val0_buf;
                val1_ff <= val1_buf;
            end
            if (!enable) begin
                div_ff   <= 3'h0;
                cnt_ff   <= {CW{1'b0}};
                down_ff  <= 1'b0;
                first_ff <= 1'b1;
                out0_ff  <= 1'b0;
                out1_ff  <= 1'b0;
            end else if (tick) begin
                div_ff   <= 3'h0;
                cnt_ff   <= nxt_cnt;
                down_ff  <= nxt_down;
                first_ff <= 1'b0;
                out0_ff  <= nxt_out(v0_use, mod_use, nxt_cnt, nxt_down, reload,
                                    edge_align_select, out0_ff);
                out1_ff  <= nxt_out(v1_use, mod_use, nxt_cnt, nxt_down, reload,
                                    edge_align_select, out1_ff);
            end else begin
                div_ff <= div_ff + 3'h1;
            end
        end
    end
endmodule

// >>> hdl/mpg_top.v
// Motor PWM generator core: AXI4-Lite register file and three PWM generators
`timescale 1ns/1ps
`include "mpg_consts.vh"
module mpg_top #(
    parameter AW = 8                     // AXI address width
) (
    input  wire          aclk,
    input  wire          aresetn,
    input  wire [AW-1:0] s_axi_awaddr,
    input  wire [2:0]    s_axi_awprot,
    input  wire          s_axi_awvalid,
    output wire          s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output wire          s_axi_wready,
    output wire [1:0]    s_axi_bresp,
    output wire          s_axi_bvalid,
    input  wire          s_axi_bready,
    input  wire [AW-1:0] s_axi_araddr,
    input  wire [2:0]    s_axi_arprot,
    input  wire          s_axi_arvalid,
    output wire          s_axi_arready,
    output wire [31:0]   s_axi_rdata,
    output wire [1:0]    s_axi_rresp,
    output wire          s_axi_rvalid,
    input  wire          s_axi_rready,
    output wire [5:0]    pwm_out
);
    // Bus handshake state
    reg          awready_ff;             // Address slot free
    reg          wready_ff;              // Data slot free
    reg          aw_hold_ff;             // Write address captured
    reg          w_hold_ff;              // Write data captured
    reg [7:0]    awaddr_ff;
    reg [31:0]   wdata_ff;
    reg [3:0]    wstrb_ff;
    reg          bvalid_ff;
    reg [1:0]    bresp_ff;
    reg          arready_ff;
    reg          rvalid_ff;
    reg [31:0]   rdata_ff;
    reg [1:0]    rresp_ff;
    // Register contents
    reg [35:0]   dt_ff;                  // Deadtime counts A, B, C
    reg [44:0]   mod_ff;                 // Buffered moduli A, B, C
    reg [95:0]   val_ff;                 // Buffered pulse width values 0..5
    reg          mtg_ff;                 // multi_generator_select
    reg          wp_ff;                  // Deadtime write lock, sticky
    reg [2:0]    edge_ff;                // edge_align_select per pair
    reg [2:0]    en_ff;                  // Generator enables
    reg [2:0]    ldok_ff;                // Load-okay bits, C is load_okay_pair_c
    reg [5:0]    psc_ff;                 // Buffered divisors, C is pair_c_clock_divisor
    // Generator results
    wire [44:0]  gen_cnt;
    wire [5:0]   gen_psc;
    wire [2:0]   gen_loaded;
    wire [5:0]   gen_out;
    // Write and read path helpers
    wire [7:0]   wa      = {awaddr_ff[7:2], 2'b00};
    wire [7:0]   voff    = wa - `MPG_VAL0;
    wire [2:0]   vidx    = voff[4:2];
    wire         do_write = aw_hold_ff & w_hold_ff & ~bvalid_ff;
    wire [31:0]  wmask   = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                            {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    reg [32:0]   wr_old;                 // Contents at the write address, bit 32 mapped
    wire [31:0]  wr_val  = (wr_old[31:0] & ~wmask) | (wdata_ff & wmask);
    wire [7:0]   ra      = {s_axi_araddr[7:2], 2'b00};
    reg [32:0]   rd_now;                 // Contents at the read address, bit 32 mapped
    integer      i;

    // Register lookups for both channels
    // The list is spelled out: an implicit one would miss the state read inside rd_reg,
    // and a read of an unchanged address would then return stale contents
    always @(wa or ra or dt_ff or mod_ff or val_ff or mtg_ff or wp_ff or edge_ff
             or en_ff or ldok_ff or psc_ff or gen_cnt or gen_psc) begin
        wr_old = rd_reg(wa);
        rd_now = rd_reg(ra);
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign pwm_out       = gen_out;      // Pairs A, B, C on bits 1:0, 3:2, 5:4

    // Deadtime in bus clocks: count when undivided, else P * count - 1
    function [14:0] eff_dt;
        input [11:0] dt;
        input [1:0]  p;
        reg   [14:0] sh;
        begin
            sh = {3'b000, dt} << p;
            if (p == 2'b00) begin
                eff_dt = {3'b000, dt};
            end else if (sh == 15'h0000) begin
                eff_dt = 15'h0000;
            end else begin
                eff_dt = sh - 15'h0001;
            end
        end
    endfunction

    // Register read mux; bit 32 marks a mapped address
    function [32:0] rd_reg;
        input [7:0] a;
        reg   [7:0] off;
        begin
            off    = a - `MPG_VAL0;
            rd_reg = {1'b1, 32'h0000_0000};
            case (a)
                `MPG_DT_C:  rd_reg[11:0] = dt_ff[35:24];
                `MPG_DT_A:  rd_reg[11:0] = dt_ff[11:0];
                `MPG_DT_B:  rd_reg[11:0] = dt_ff[23:12];
                `MPG_CFG: begin
                    rd_reg[`MPG_CFG_MTG]                 = mtg_ff;
                    rd_reg[`MPG_CFG_WP]                  = wp_ff;
                    rd_reg[`MPG_CFG_EDGE+1:`MPG_CFG_EDGE] = edge_ff[1:0];
                    rd_reg[`MPG_CFG_EDGE+2]              = edge_ff[2] & mtg_ff;
                end
                `MPG_CTL: begin
                    // Pair C fields read zero in single mode
                    rd_reg[`MPG_CTL_EN+1:`MPG_CTL_EN]     = en_ff[1:0];
                    rd_reg[`MPG_CTL_EN+2]                 = en_ff[2] & mtg_ff;
                    rd_reg[`MPG_CTL_LDOK+1:`MPG_CTL_LDOK] = ldok_ff[1:0];
                    rd_reg[`MPG_CTL_LDOK+2]               = ldok_ff[2] & mtg_ff;
                    rd_reg[`MPG_CTL_PSC+3:`MPG_CTL_PSC]   = psc_ff[3:0];
                    rd_reg[`MPG_CTL_PSC+5:`MPG_CTL_PSC+4] = psc_ff[5:4] & {2{mtg_ff}};
                end
                // Moduli read back the buffered value, not the working one
                `MPG_MOD_A: rd_reg[14:0] = mod_ff[14:0];
                `MPG_MOD_B: rd_reg[14:0] = mod_ff[29:15];
                `MPG_MOD_C: rd_reg[14:0] = mod_ff[44:30];
                `MPG_CNT_A: rd_reg[14:0] = gen_cnt[14:0];
                `MPG_CNT_B: rd_reg[14:0] = gen_cnt[29:15];
                `MPG_CNT_C: rd_reg[14:0] = gen_cnt[44:30];
                `MPG_EDT_A: rd_reg[14:0] = eff_dt(dt_ff[11:0], gen_psc[1:0]);
                `MPG_EDT_B: rd_reg[14:0] = eff_dt(dt_ff[23:12], gen_psc[3:2]);
                `MPG_EDT_C: rd_reg[14:0] = eff_dt(dt_ff[35:24], gen_psc[5:4]);
                default: begin
                    if (a >= `MPG_VAL0 && a <= `MPG_VAL5) begin
                        rd_reg[15:0] = val_ff[{off[4:2], 4'h0} +: 16];
                    end else begin
                        rd_reg[32] = 1'b0;
                    end
                end
            endcase
        end
    endfunction

    // Write channels: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `MPG_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && awready_ff) begin
                awaddr_ff  <= s_axi_awaddr[7:0];
                aw_hold_ff <= 1'b1;
                awready_ff <= 1'b0;
            end
            if (s_axi_wvalid && wready_ff) begin
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
                w_hold_ff <= 1'b1;
                wready_ff <= 1'b0;
            end
            if (do_write) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                // Unmapped addresses answer with a slave error
                bresp_ff   <= wr_old[32] ? `MPG_RESP_OKAY : `MPG_RESP_SLVERR;
            end
            // Slots reopen only after the response is taken
            if (bvalid_ff && s_axi_bready) begin
                bvalid_ff  <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff  <= 1'b1;
            end
        end
    end

    // Read channel: data registered one cycle after the address
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= `MPG_RESP_OKAY;
        end else if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rd_now[31:0];
            rresp_ff   <= rd_now[32] ? `MPG_RESP_OKAY : `MPG_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    // Register file; a software write lands after the hardware clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            dt_ff   <= {3{`MPG_DT_RST}};
            mod_ff  <= {3{`MPG_MOD_RST}};
            val_ff  <= {6{`MPG_VAL_RST}};
            mtg_ff  <= 1'b0;
            wp_ff   <= 1'b0;
            edge_ff <= 3'b000;
            en_ff   <= 3'b000;
            ldok_ff <= 3'b000;
            psc_ff  <= 6'h00;
        end else begin
            // Load-okay drops once its generator has taken the buffers
            for (i = 0; i < 3; i = i + 1) begin
                if (gen_loaded[i] && (mtg_ff || i == 0)) begin
                    ldok_ff[i] <= 1'b0;
                end
            end
            if (do_write) begin
                case (wa)
                    `MPG_DT_A: if (!wp_ff) dt_ff[11:0] <= wr_val[11:0];
                    `MPG_DT_B: if (!wp_ff) dt_ff[23:12] <= wr_val[11:0];
                    `MPG_DT_C: begin
                        if (!wp_ff && mtg_ff) begin
                            dt_ff[35:24] <= wr_val[11:0];
                        end
                    end
                    `MPG_CFG: begin
                        mtg_ff       <= wr_val[`MPG_CFG_MTG];
                        // Lock only ever sets; reset alone releases it
                        wp_ff        <= wp_ff | wr_val[`MPG_CFG_WP];
                        edge_ff[1:0] <= wr_val[`MPG_CFG_EDGE+1:`MPG_CFG_EDGE];
                        if (mtg_ff) begin
                            edge_ff[2] <= wr_val[`MPG_CFG_EDGE+2];
                        end
                    end
                    `MPG_CTL: begin
                        // Writing zero to a load-okay bit cancels a pending load
                        en_ff[1:0]   <= wr_val[`MPG_CTL_EN+1:`MPG_CTL_EN];
                        ldok_ff[1:0] <= wr_val[`MPG_CTL_LDOK+1:`MPG_CTL_LDOK];
                        psc_ff[3:0]  <= wr_val[`MPG_CTL_PSC+3:`MPG_CTL_PSC];
                        if (mtg_ff) begin
                            en_ff[2]    <= wr_val[`MPG_CTL_EN+2];
                            ldok_ff[2]  <= wr_val[`MPG_CTL_LDOK+2];
                            psc_ff[5:4] <= wr_val[`MPG_CTL_PSC+5:`MPG_CTL_PSC+4];
                        end
                    end
                    `MPG_MOD_A: mod_ff[14:0] <= wr_val[14:0];
                    `MPG_MOD_B: mod_ff[29:15] <= wr_val[14:0];
                    `MPG_MOD_C: if (mtg_ff) mod_ff[44:30] <= wr_val[14:0];
                    default: begin
                        if (wa >= `MPG_VAL0 && wa <= `MPG_VAL5) begin
                            val_ff[{vidx, 4'h0} +: 16] <= wr_val[15:0];
                        end
                    end
                endcase
            end
        end
    end

    // Three generators; in single mode B and C run in lockstep on A's settings
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gen_pair
            wire own = mtg_ff || (g == 0);
            mpg_gen #(
                .CW (15),
                .VW (16)
            ) u_gen (
                .aclk              (aclk),
                .aresetn           (aresetn),
                .enable            (own ? en_ff[g] : en_ff[0]),
                .edge_align_select (own ? edge_ff[g] : edge_ff[0]),
                .load_okay         (own ? ldok_ff[g] : ldok_ff[0]),
                .psc_buf           (own ? psc_ff[2*g +: 2] : psc_ff[1:0]),
                .mod_buf           (own ? mod_ff[15*g +: 15] : mod_ff[14:0]),
                .val0_buf          (val_ff[32*g +: 16]),
                .val1_buf          (val_ff[32*g+16 +: 16]),
                .count             (gen_cnt[15*g +: 15]),
                .psc_work          (gen_psc[2*g +: 2]),
                .loaded            (gen_loaded[g]),
                .out0              (gen_out[2*g]),
                .out1              (gen_out[2*g+1])
            );
        end
    endgenerate
endmodule

// >>> test/mpg_top_monitor.sv
// Register bus handshake checker for the motor PWM generator core
`timescale 1ns/1ps
module mpg_top_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Write is answered two edges after both halves are taken
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer changed");
    a_b_done: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not closed");
    a_r_done: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid && s_axi_arready) else $error("read not closed");
    a_aw_closed: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    a_ar_closed: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
endmodule
bind mpg_top mpg_top_monitor u_mon (.*);

// >>> test/mpg_stage.sv
// Power stage load: counts wrong-level cycles on the pair C drives
`timescale 1ns/1ps
module mpg_stage (
    input wire logic        aclk,
    input wire logic        clr,
    input wire logic [5:0]  pwm_out,
    output logic     [15:0] on_cnt,
    output logic     [15:0] off_cnt
);
    // Top drive should stay off, bottom drive should stay on
    always @(posedge aclk) begin
        on_cnt  <= clr ? 16'h0 : on_cnt + {15'h0, pwm_out[4]};
        off_cnt <= clr ? 16'h0 : off_cnt + {15'h0, !pwm_out[5]};
    end
endmodule

// >>> test/mpg_top_tb_top.sv
// Self-checking bench for the motor PWM generator core
`timescale 1ns/1ps
`include "mpg_consts.vh"
`define CHK(a,e) begin checks_done++; if ((a)!==(e)) begin error_cnt++; \
    $display("ERROR %0t got %h exp %h", $time, a, e); end end
module mpg_top_tb_top;
    reg aclk = 1'h0, aresetn = 1'h0, clr = 1'h0;
    reg [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    reg [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    reg [3:0] s_axi_wstrb = 4'hF;
    reg [31:0] s_axi_wdata = 32'h0;
    reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [5:0] pwm_out;
    wire [15:0] on_cnt, off_cnt;
    integer error_cnt = 0, checks_done = 0, seed = 32'h2B97;
    reg [33:0] rq[$], exp_r;
    reg [1:0] bq[$], exp_b;
    reg [11:0] dt;
    mpg_top uut (.*);
    mpg_stage u_stage (.*);
    initial forever #2.5 aclk = !aclk;
    task end_sim;
        begin
            if (error_cnt == 0 && checks_done > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // Bounded wait failed: count it and close the run
    task hang;
        begin
            error_cnt++;
            $display("ERROR %0t bus wait timed out", $time);
            end_sim;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] r);
        int i;
        begin
            bq.push_back(r);
            s_axi_awaddr <= a; s_axi_wdata <= d;
            s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1; s_axi_bready <= 1'h1;
            for (i = 0; i < 200; i++) begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'h0;
                if (s_axi_wready) s_axi_wvalid <= 1'h0;
                if (s_axi_bvalid) break;
            end
            if (i == 200) hang;
            s_axi_bready <= 1'h0;
            @(posedge aclk);
        end
    endtask
    task rd(input [7:0] a, input [33:0] e);
        int i;
        begin
            rq.push_back(e);
            s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
            for (i = 0; i < 200; i++) begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 1'h0;
                if (s_axi_rvalid) break;
            end
            if (i == 200) hang;
            s_axi_rready <= 1'h0;
            @(posedge aclk);
        end
    endtask
    // Answers are matched against the oldest pending note
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
            exp_r = rq.pop_front();
            `CHK(({s_axi_rresp, s_axi_rdata}), exp_r)
        end
        if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
            exp_b = bq.pop_front();
            `CHK(s_axi_bresp, exp_b)
        end
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        dt = {$random(seed)} % 4095 + 1;
        rd(`MPG_DT_C, 34'hFFF);
        wr(`MPG_MOD_C, 32'h55, 2'h0);
        rd(`MPG_MOD_C, 34'h0);
        wr(`MPG_CFG, 32'h11, 2'h0);
        wr(`MPG_DT_C, {20'h0, dt}, 2'h0);
        rd(`MPG_DT_C, {22'h0, dt});
        wr(`MPG_MOD_C, 32'hA, 2'h0);
        wr(`MPG_VAL5 - 8'h04, 32'h8000, 2'h0);
        wr(`MPG_VAL5, 32'h7FFF, 2'h0);
        rd(`MPG_MOD_C, 34'hA);
        wr(`MPG_CTL, 32'h1044, 2'h0);
        repeat (40) @(posedge aclk);
        rd(`MPG_CTL, 34'h1004);
        rd(`MPG_EDT_C, {21'h0, dt, 1'h0} - 34'h1);
        rd(`MPG_EDT_A, 34'hFFF);
        rd(`MPG_CNT_A, 34'h0);
        clr <= 1'h1;
        @(posedge aclk);
        clr <= 1'h0;
        repeat (60) @(posedge aclk);
        `CHK(on_cnt, 16'h0)
        `CHK(off_cnt, 16'h0)
        `CHK(pwm_out[3:0], 4'h0)
        wr(`MPG_CFG, 32'h13, 2'h0);
        wr(`MPG_DT_C, 32'h0, 2'h0);
        rd(`MPG_DT_C, {22'h0, dt});
        wr(`MPG_CFG, 32'h12, 2'h0);
        rd(`MPG_CTL, 34'h0);
        wr(`MPG_MOD_C, 32'h3, 2'h0);
        rd(`MPG_MOD_C, 34'hA);
        wr(8'h80, 32'h1, 2'h2);
        rd(8'h80, 34'h200000000);
        repeat (4) @(posedge aclk);
        end_sim;
    end
endmodule
